// ### rtl/nib_fifo_host.sv
/*
  Host controller that drives a 16x4 ripple FIFO through its pins and takes
  orders from software over AXI4-Lite. Assumes the FIFO flags and data are
  asynchronous to clk and are synchronised here.
*/
// Register access over AXI4-Lite and the address map were chosen for this implementation.
// Behaviour
// - Host pulses master clear after power-up before transfers.
// - Host raises shift-in only while input flag is high.
// - Host returns shift-in low to complete each write.
// - Host holds shift-in high until the input flag is seen low, then releases it.
// - Host never issues more writes than remaining storage accepts.
`timescale 1ns/1ps
module nib_fifo_host (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // AXI4-Lite slave
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // FIFO pins
  output logic master_clear,
  output logic shift_in_strobe,
  output logic [nib_fifo_pkg::WIDTH-1:0] write_nibble,
  input wire logic in_ready_flag,
  output logic shift_out_strobe,
  input wire logic out_ready_flag,
  input wire logic [nib_fifo_pkg::WIDTH-1:0] read_nibble,
  output logic drive_enable_n
);

  nib_fifo_pkg::state_t s_reg;
  nib_fifo_pkg::state_t s_next;
  logic wr_fire;
  logic rd_fire;
  logic clear_req;

  ////////////////////////////////////////////////////////////////////////////
  assign wr_fire = (s_reg.awv || (s_awvalid && s_awready)) &&
                   (s_reg.wv || (s_wvalid && s_wready)) && !s_reg.bvalid;
  assign rd_fire = s_arvalid && !s_reg.rvalid;
  assign s_awready = !s_reg.awv && !s_reg.bvalid;
  assign s_wready = !s_reg.wv && !s_reg.bvalid;
  assign s_arready = !s_reg.rvalid;

  always_comb begin
    s_next = s_reg;
    clear_req = 1'b0;
    // Three-stage synchronisers; flag change taken when stages 2 and 3 agree, data taken from stage 3
    s_next.in_ready_sync = {s_reg.in_ready_sync[1:0], in_ready_flag};
    s_next.out_ready_sync = {s_reg.out_ready_sync[1:0], out_ready_flag};
    s_next.rd_sync = {s_reg.rd_sync[1:0], read_nibble};
    if (s_reg.in_ready_sync[2] == s_reg.in_ready_sync[1]) begin
      s_next.in_ready = s_reg.in_ready_sync[2];
    end
    if (s_reg.out_ready_sync[2] == s_reg.out_ready_sync[1]) begin
      s_next.out_ready = s_reg.out_ready_sync[2];
    end
    // AXI write capture
    if (s_awvalid && s_awready) begin
      s_next.awv = 1'b1;
      s_next.awaddr = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      s_next.wv = 1'b1;
      s_next.wdata = s_wdata;
    end
    if (s_reg.bvalid && s_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (wr_fire) begin
      s_next.awv = 1'b0;
      s_next.wv = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = nib_fifo_pkg::RESP_OKAY;
      unique case (s_next.awaddr)
        nib_fifo_pkg::CTRL_OFF: begin
          if (s_wstrb[0]) begin
            s_next.oe_n = !s_next.wdata[nib_fifo_pkg::CTRL_OE_BIT];
            if (s_next.wdata[nib_fifo_pkg::CTRL_CLEAR_BIT]) begin
              clear_req = 1'b1;
            end
          end
        end
        nib_fifo_pkg::WDATA_OFF: begin
          if (s_reg.wpend) begin
            s_next.bresp = nib_fifo_pkg::RESP_SLVERR;
          end else begin
            s_next.wnib = s_next.wdata[nib_fifo_pkg::WIDTH-1:0];
            s_next.wpend = 1'b1;
          end
        end
        nib_fifo_pkg::STATUS_OFF: begin
          // request one word taken from the output stage
          if (s_next.wdata[nib_fifo_pkg::ST_OUT_READY_BIT]) begin
            s_next.rpend = 1'b1;
          end
        end
        nib_fifo_pkg::RDATA_OFF: s_next.rvalid_data = 1'b0;
        default: s_next.bresp = nib_fifo_pkg::RESP_SLVERR;
      endcase
    end
    // AXI read
    if (s_reg.rvalid && s_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (rd_fire) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = nib_fifo_pkg::RESP_OKAY;
      s_next.rdata = 32'h0;
      unique case (s_araddr)
        nib_fifo_pkg::CTRL_OFF: begin
          s_next.rdata[nib_fifo_pkg::CTRL_OE_BIT] = !s_reg.oe_n;
        end
        nib_fifo_pkg::WDATA_OFF: s_next.rdata[nib_fifo_pkg::WIDTH-1:0] = s_reg.wnib;
        nib_fifo_pkg::STATUS_OFF: begin
          s_next.rdata[nib_fifo_pkg::ST_IN_READY_BIT] = s_reg.in_ready;
          s_next.rdata[nib_fifo_pkg::ST_OUT_READY_BIT] = s_reg.out_ready;
          s_next.rdata[nib_fifo_pkg::ST_BUSY_BIT] = s_reg.wpend || s_reg.rpend;
          s_next.rdata[nib_fifo_pkg::ST_RVALID_BIT] = s_reg.rvalid_data;
          s_next.rdata[nib_fifo_pkg::ST_INIT_BIT] = s_reg.seq == nib_fifo_pkg::ST_INIT;
        end
        nib_fifo_pkg::RDATA_OFF: s_next.rdata[nib_fifo_pkg::WIDTH-1:0] = s_reg.rnib;
        default: s_next.rresp = nib_fifo_pkg::RESP_SLVERR;
      endcase
    end
    // Pin sequencer
    unique case (s_reg.seq)
      nib_fifo_pkg::ST_INIT: begin
        // master clear pulse before any transfer
        s_next.clear = 1'b1;
        s_next.si = 1'b0;
        s_next.so = 1'b1;
        s_next.wpend = 1'b0;
        s_next.rpend = 1'b0;
        s_next.cnt = s_reg.cnt + 4'h1;
        if (s_reg.cnt >= nib_fifo_pkg::PULSE_CNT) begin
          s_next.clear = 1'b0;
          s_next.cnt = 4'h0;
          s_next.seq = nib_fifo_pkg::ST_IDLE;
        end
      end
      nib_fifo_pkg::ST_IDLE: begin
        s_next.cnt = 4'h0;
        // shift in only on a settled input flag
        // never shift in without room shown
        if (s_reg.wpend && s_reg.in_ready && !s_reg.clear) begin
          s_next.si = 1'b1;
          s_next.seq = nib_fifo_pkg::ST_SI_HI;
        end else if (s_reg.rpend && s_reg.out_ready && !s_reg.clear) begin
          s_next.rnib = s_reg.rd_sync[2];
          s_next.rvalid_data = 1'b1;
          s_next.so = 1'b0;
          s_next.seq = nib_fifo_pkg::ST_SO_HI;
        end
      end
      nib_fifo_pkg::ST_SI_HI: begin
        s_next.cnt = s_reg.cnt + 4'h1;
        // wait until the busy low is seen, then release
        if (s_reg.cnt >= nib_fifo_pkg::PULSE_CNT && !s_reg.in_ready) begin
          // return the strobe low to finish the write
          s_next.si = 1'b0;
          s_next.wpend = 1'b0;
          s_next.cnt = 4'h0;
          s_next.seq = nib_fifo_pkg::ST_SI_LO;
        end
      end
      nib_fifo_pkg::ST_SI_LO, nib_fifo_pkg::ST_SO_LO: begin
        s_next.cnt = s_reg.cnt + 4'h1;
        if (s_reg.cnt >= nib_fifo_pkg::PULSE_CNT) begin
          s_next.cnt = 4'h0;
          s_next.seq = nib_fifo_pkg::ST_IDLE;
        end
      end
      nib_fifo_pkg::ST_SO_HI: begin
        s_next.cnt = s_reg.cnt + 4'h1;
        // rising shift-out edge after the flag is seen low
        if (s_reg.cnt >= nib_fifo_pkg::PULSE_CNT && !s_reg.out_ready) begin
          s_next.so = 1'b1;
          s_next.rpend = 1'b0;
          s_next.cnt = 4'h0;
          s_next.seq = nib_fifo_pkg::ST_SO_LO;
        end
      end
      default: s_next.seq = nib_fifo_pkg::ST_INIT;
    endcase
    // Clear order wins over the sequencer's next state and count in the same cycle
    if (clear_req) begin
      s_next.seq = nib_fifo_pkg::ST_INIT;
      s_next.cnt = 4'h0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0;
      s_reg.so <= 1'b1;
      s_reg.oe_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign s_bvalid = s_reg.bvalid;
  assign s_bresp = s_reg.bresp;
  assign s_rvalid = s_reg.rvalid;
  assign s_rdata = s_reg.rdata;
  assign s_rresp = s_reg.rresp;
  assign master_clear = s_reg.clear;
  assign shift_in_strobe = s_reg.si;
  assign write_nibble = s_reg.wnib;
  // drive enable from the control register
  assign shift_out_strobe = s_reg.so;
  assign drive_enable_n = s_reg.oe_n;

  ////////////////////////////////////////////////////////////////////////////
  // shift-in rises only from idle with settled ready
  chk_si_rise_ready: assert property (@(posedge clk) disable iff (!rstn)
    $rose(shift_in_strobe) |-> $past(s_reg.in_ready) && !master_clear)
    else $error("shift-in raised without input ready");
  // clear held a full pulse after reset
  chk_clear_first: assert property (@(posedge clk) disable iff (!rstn)
    $fell(master_clear) |-> $past(s_reg.cnt) >= nib_fifo_pkg::PULSE_CNT)
    else $error("master clear pulse too short");
  // strobe falls only after busy seen
  chk_si_fall_busy: assert property (@(posedge clk) disable iff (!rstn)
    $fell(shift_in_strobe) |-> $past(!s_reg.in_ready))
    else $error("shift-in released before busy");
  chk_si_no_clear: assert property (@(posedge clk) disable iff (!rstn)
    master_clear |-> !shift_in_strobe)
    else $error("shift-in during master clear");
  chk_so_fall_ready: assert property (@(posedge clk) disable iff (!rstn)
    $fell(shift_out_strobe) |-> $past(s_reg.out_ready))
    else $error("shift-out without data ready");
  chk_so_rise_flag: assert property (@(posedge clk) disable iff (!rstn)
    $rose(shift_out_strobe) |-> $past(!s_reg.out_ready))
    else $error("shift-out released before flag drop");
  chk_one_strobe: assert property (@(posedge clk) disable iff (!rstn)
    !(shift_in_strobe && !shift_out_strobe))
    else $error("both strobes active");
  chk_wnib_stable: assert property (@(posedge clk) disable iff (!rstn)
    shift_in_strobe && $past(shift_in_strobe) |-> $stable(write_nibble))
    else $error("write nibble changed during shift-in");
endmodule

// ### rtl/nib_fifo_pkg.sv
/*
  Package for the host controller of a 16-word by 4-bit ripple FIFO.
  Assumes one 100 MHz clock and an AXI4-Lite register port.
*/
package nib_fifo_pkg;
  localparam int DEPTH = 16;
  localparam int WIDTH = 4;
  // Register byte offsets
  localparam logic [3:0] CTRL_OFF = 4'h0;
  localparam logic [3:0] WDATA_OFF = 4'h4;
  localparam logic [3:0] STATUS_OFF = 4'h8;
  localparam logic [3:0] RDATA_OFF = 4'hc;
  // CTRL fields
  localparam int CTRL_CLEAR_BIT = 0;
  localparam int CTRL_OE_BIT = 1;
  // STATUS fields
  localparam int ST_IN_READY_BIT = 0;
  localparam int ST_OUT_READY_BIT = 1;
  localparam int ST_BUSY_BIT = 2;
  localparam int ST_RVALID_BIT = 3;
  localparam int ST_INIT_BIT = 4;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int PULSE_NS = 40;
  localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] PULSE_CNT = 4'(PULSE_CYC);
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_INIT = 3'h0,
    ST_IDLE = 3'h1,
    ST_SI_HI = 3'h3,
    ST_SI_LO = 3'h2,
    ST_SO_HI = 3'h6,
    ST_SO_LO = 3'h7
  } seq_t;

  typedef struct packed {
    logic [2:0] in_ready_sync;
    logic [2:0] out_ready_sync;
    logic in_ready;
    logic out_ready;
    logic [2:0][WIDTH-1:0] rd_sync;
    seq_t seq;
    logic [3:0] cnt;
    logic clear;
    logic si;
    logic so;
    logic oe_n;
    logic [WIDTH-1:0] wnib;
    logic wpend;
    logic rpend;
    logic [WIDTH-1:0] rnib;
    logic rvalid_data;
    logic awv;
    logic wv;
    logic [3:0] awaddr;
    logic [31:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;
endpackage

// ### dv/ripple_fifo_model.sv
/*
  Behavioural model of the 16x4 ripple FIFO seen from its pins.
  Assumes one host drives the pins; ripple timing is coarse.
*/
`timescale 1ns/1ps
module ripple_fifo_model (
  // Control
  input wire logic master_clear,
  input wire logic shift_in_strobe,
  input wire logic shift_out_strobe,
  input wire logic drive_enable_n,
  // Data and flags
  input wire logic [3:0] write_nibble,
  output logic in_ready_flag,
  output logic out_ready_flag,
  output wire [3:0] read_nibble
);
  logic [3:0] store[$];
  logic [3:0] in_word;
  logic [3:0] out_stage = 4'ha;
  logic loading = 1'h0;
  int settle = 0;
  initial in_ready_flag = 1'h0;
  initial out_ready_flag = 1'h0;
  always @(posedge master_clear) begin
    store.delete();
    loading = 1'h0;
    out_ready_flag = 1'h0;
    in_ready_flag = 1'h1;
  end
  always @(posedge shift_in_strobe or negedge master_clear or posedge in_ready_flag) begin
    if (!master_clear && shift_in_strobe && !loading && in_ready_flag) begin
      in_word = write_nibble;
      loading = 1'h1;
      in_ready_flag = 1'h0;
    end
  end
  always @(negedge shift_out_strobe) begin
    if (!master_clear && out_ready_flag) begin
      out_ready_flag = 1'h0;
      settle = 3;
    end
  end
  always #7 begin
    if (loading && !shift_in_strobe && !master_clear) begin
      store.push_back(in_word);
      loading = 1'h0;
    end
    if (settle != 0) begin
      settle--;
    end else if (!out_ready_flag && store.size() != 0) begin
      out_stage = store.pop_front();
      out_ready_flag = 1'h1;
    end
    if (!loading && !master_clear) begin
      in_ready_flag = (store.size() + int'(out_ready_flag)) < 16;
    end
  end
  assign read_nibble = drive_enable_n ? 4'hz : out_stage;
  // Released port drifts away from the last word
  assign (weak0, weak1) read_nibble = ~out_stage;
endmodule

// ### dv/elastic_nibble_fifo_16x4_tb.sv
/*
  Self-checking bench for the nibble FIFO host over AXI4-Lite.
  Assumes the ripple FIFO model stands on the FIFO pins.
*/
`timescale 1ns/1ps
module elastic_nibble_fifo_16x4_tb;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, mclr, si, so, oe_n, irdy, ordy;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, st;
  logic [3:0] wnib;
  wire [3:0] rnib;
  int mismatches = 0;
  int n_compared = 0;

  initial forever #5 clk = ~clk;

  nib_fifo_host i_dut (
    .clk(clk), .rstn(rstn), .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
    .s_wdata(wdata), .s_wstrb(4'hf), .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp),
    .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
    .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
    .s_rready(rready), .master_clear(mclr), .shift_in_strobe(si), .write_nibble(wnib),
    .in_ready_flag(irdy), .shift_out_strobe(so), .out_ready_flag(ordy),
    .read_nibble(rnib), .drive_enable_n(oe_n));

  ripple_fifo_model i_fifo (
    .master_clear(mclr), .shift_in_strobe(si), .shift_out_strobe(so),
    .drive_enable_n(oe_n), .write_nibble(wnib), .in_ready_flag(irdy),
    .out_ready_flag(ordy), .read_nibble(rnib));

  task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: resp %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    fork
      begin @(posedge clk iff awready); awvalid <= 1'h0; end
      begin @(posedge clk iff wready); wvalid <= 1'h0; end
    join
    @(posedge clk iff bvalid);
    resp = bresp;
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    @(posedge clk iff arready);
    arvalid <= 1'h0;
    @(posedge clk iff rvalid);
    st = rdata;
    resp = rresp;
    rready <= 1'h0;
  endtask

  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      rd(nib_fifo_pkg::STATUS_OFF);
      n++;
    end while (st[b] !== v && n < 400);
    cmp_data(32'(st[b]), 32'(v));
  endtask

  task automatic push(input logic [3:0] d);
    poll(nib_fifo_pkg::ST_INIT_BIT, 1'h0);
    poll(nib_fifo_pkg::ST_BUSY_BIT, 1'h0);
    wr(nib_fifo_pkg::WDATA_OFF, {28'h0, d});
    cmp_resp(resp, nib_fifo_pkg::RESP_OKAY);
  endtask

  task automatic pop(input logic [3:0] d);
    poll(nib_fifo_pkg::ST_BUSY_BIT, 1'h0);
    wr(nib_fifo_pkg::RDATA_OFF, 32'h0);
    wr(nib_fifo_pkg::STATUS_OFF, 32'h2);
    poll(nib_fifo_pkg::ST_RVALID_BIT, 1'h1);
    rd(nib_fifo_pkg::RDATA_OFF);
    cmp_data(st, {28'h0, d});
  endtask

  task automatic t_init;
    poll(nib_fifo_pkg::ST_INIT_BIT, 1'h0);
    cmp_data({30'h0, st[1:0]}, 32'h1);
    wr(nib_fifo_pkg::CTRL_OFF, 32'h2);
    @(posedge clk);
    cmp_data({31'h0, oe_n}, 32'h0);
    $display("test init done");
  endtask

  task automatic t_order;
    logic [3:0] v[5] = '{4'h3, 4'hc, 4'h0, 4'hf, 4'h9};
    foreach (v[i]) push(v[i]);
    foreach (v[i]) pop(v[i]);
    $display("test order done");
  endtask

  task automatic t_full;
    for (int i = 0; i < 16; i++) push(4'(i));
    poll(nib_fifo_pkg::ST_BUSY_BIT, 1'h0);
    cmp_data({30'h0, st[1:0]}, 32'h2);
    pop(4'h0);
    poll(nib_fifo_pkg::ST_IN_READY_BIT, 1'h1);
    push(4'h5);
    for (int i = 1; i < 16; i++) pop(4'(i));
    pop(4'h5);
    poll(nib_fifo_pkg::ST_OUT_READY_BIT, 1'h0);
    $display("test full done");
  endtask

  task automatic t_clear;
    push(4'h6);
    push(4'h7);
    poll(nib_fifo_pkg::ST_BUSY_BIT, 1'h0);
    wr(nib_fifo_pkg::CTRL_OFF, 32'h3);
    poll(nib_fifo_pkg::ST_INIT_BIT, 1'h0);
    poll(nib_fifo_pkg::ST_BUSY_BIT, 1'h0);
    cmp_data({30'h0, st[1:0]}, 32'h1);
    push(4'h8);
    pop(4'h8);
    $display("test clear done");
  endtask

  task automatic t_err;
    wr(4'h2, 32'h1);
    cmp_resp(resp, nib_fifo_pkg::RESP_SLVERR);
    rd(4'h6);
    cmp_resp(resp, nib_fifo_pkg::RESP_SLVERR);
    $display("test error done");
  endtask

  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'h1;
    t_init();
    t_order();
    t_full();
    t_clear();
    t_err();
    conclude();
  end

  initial begin
    #500000;
    mismatches++;
    conclude();
  end
endmodule
